// ==== rtl/ptm_top.sv ====
// module: periodic timer with axi4-lite registers
`timescale 1ns/1ps
// Function
// - counter readable as low and high bytes
// - compare a, ten bits, two bytes, reset zero
// - period compare, ten bits, two bytes
// - high byte bits seven to two read zero
// - two-bit mode field selects operating mode
// - compare mode: clear on p, both flags
// - clear select high: clear on a, a only
// - pin changes only on a match or a run rise
// - a match drives high, low, toggles, or nothing
// - action codes: none, low, high, toggle
// - run rise loads initial level onto pin
// - run rise clears counter, fall holds it
// - timer mode counts like compare, no pin
// - pwm ignores clear select; p period, a duty
// - period zero means 1024 counts
// - pwm raises both flags on matches
// - initial level picks pwm polarity, action forces
// - pwm actions: inactive, active, wave, pulse
// - invert bit inverts pin
// - duty at or above period: full duty
// - counter keeps running while pin forced
module ptm_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             timer_output_pin,
  output logic             timer_output_enable
);

  // ==========================================================================
  // registers
  logic [7:0]                  ctrl0_q;
  ptm_pkg::timer_control_one_t ctrl1_q;
  logic [ptm_pkg::CNT_W-1:0]   cmpa_q;
  logic [ptm_pkg::CNT_W-1:0]   per_q;
  logic                        af_q;
  logic                        pf_q;
  logic [ptm_pkg::CNT_W-1:0]   count;
  ptm_pkg::timer_cfg_t         cfg;
  ptm_pkg::timer_evt_t         evt;

  // ==========================================================================
  // write channel state
  logic [5:0] awaddr_q;
  logic       aw_held_q;
  logic [7:0] wbyte_q;
  logic       wstrb0_q;
  logic       w_held_q;
  logic       wr_go;
  logic       wr_hit;
  logic       st_clr_a;
  logic       st_clr_p;

  function automatic logic known_addr(input logic [5:0] a);
    known_addr = (a == ptm_pkg::ADDR_CNT_LO)  || (a == ptm_pkg::ADDR_CNT_HI)  ||
                 (a == ptm_pkg::ADDR_CMPA_LO) || (a == ptm_pkg::ADDR_CMPA_HI) ||
                 (a == ptm_pkg::ADDR_PER_LO)  || (a == ptm_pkg::ADDR_PER_HI)  ||
                 (a == ptm_pkg::ADDR_CTRL0)   || (a == ptm_pkg::ADDR_CTRL1)   ||
                 (a == ptm_pkg::ADDR_STATUS);
  endfunction

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign wr_go  = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_hit = wr_go && wstrb0_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= 6'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wbyte_q  <= 8'h00;
      wstrb0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wbyte_q  <= s_axi_wdata[7:0];
      wstrb0_q <= s_axi_wstrb[0];
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ptm_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= known_addr(awaddr_q) ? ptm_pkg::RESP_OKAY
                                           : ptm_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // register writes (counter bytes are read only)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0_q <= ptm_pkg::CTRL_RST;
      ctrl1_q <= ptm_pkg::timer_control_one_t'(ptm_pkg::CTRL_RST);
      cmpa_q  <= ptm_pkg::CNT_ZERO;
      per_q   <= ptm_pkg::CNT_ZERO;
    end else if (wr_hit) begin
      unique case (awaddr_q)
        ptm_pkg::ADDR_CTRL0:   ctrl0_q     <= {wbyte_q[7:3], 3'h0};
        ptm_pkg::ADDR_CTRL1:   ctrl1_q     <= wbyte_q;
        ptm_pkg::ADDR_CMPA_LO: cmpa_q[7:0] <= wbyte_q;
        ptm_pkg::ADDR_CMPA_HI: cmpa_q[9:8] <= wbyte_q[1:0];
        ptm_pkg::ADDR_PER_LO:  per_q[7:0]  <= wbyte_q;
        ptm_pkg::ADDR_PER_HI:  per_q[9:8]  <= wbyte_q[1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // match flags: write one to clear, a new match wins over the clear
  assign st_clr_a = wr_hit && awaddr_q == ptm_pkg::ADDR_STATUS &&
                    wbyte_q[ptm_pkg::ST_AF_BIT];
  assign st_clr_p = wr_hit && awaddr_q == ptm_pkg::ADDR_STATUS &&
                    wbyte_q[ptm_pkg::ST_PF_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn)          af_q <= 1'b0;
    else if (evt.a_match)  af_q <= 1'b1;
    else if (st_clr_a)     af_q <= 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)          pf_q <= 1'b0;
    else if (evt.p_match)  pf_q <= 1'b1;
    else if (st_clr_p)     pf_q <= 1'b0;
  end

  // ==========================================================================
  // read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= ptm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= known_addr(s_axi_araddr) ? ptm_pkg::RESP_OKAY
                                               : ptm_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        ptm_pkg::ADDR_CNT_LO:  s_axi_rdata <= {24'h0, count[7:0]};
        ptm_pkg::ADDR_CNT_HI:  s_axi_rdata <= {30'h0, count[9:8]};
        ptm_pkg::ADDR_CMPA_LO: s_axi_rdata <= {24'h0, cmpa_q[7:0]};
        ptm_pkg::ADDR_CMPA_HI: s_axi_rdata <= {30'h0, cmpa_q[9:8]};
        ptm_pkg::ADDR_PER_LO:  s_axi_rdata <= {24'h0, per_q[7:0]};
        ptm_pkg::ADDR_PER_HI:  s_axi_rdata <= {30'h0, per_q[9:8]};
        ptm_pkg::ADDR_CTRL0:   s_axi_rdata <= {24'h0, ctrl0_q};
        ptm_pkg::ADDR_CTRL1:   s_axi_rdata <= {24'h0, ctrl1_q};
        ptm_pkg::ADDR_STATUS:  s_axi_rdata <= {30'h0, pf_q, af_q};
        default:               s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // timer core
  assign cfg.run_control          = ctrl0_q[ptm_pkg::C0_RUN_BIT];
  assign cfg.counter_pause        = ctrl0_q[ptm_pkg::C0_PAUSE_BIT];
  assign cfg.c1                   = ctrl1_q;
  assign cfg.compare_a_value      = cmpa_q;
  assign cfg.period_compare_value = per_q;

  ptm_counter #(
    .W (ptm_pkg::CNT_W)
  ) u_counter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cfg     (cfg),
    .count_q (count),
    .evt     (evt)
  );

  ptm_output #(
    .W (ptm_pkg::CNT_W)
  ) u_output (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .cfg                 (cfg),
    .count               (count),
    .evt                 (evt),
    .timer_output_pin    (timer_output_pin),
    .timer_output_enable (timer_output_enable)
  );

endmodule // ptm_top

// ==== rtl/ptm_pkg.sv ====
// package: register map, field layout and mode codes for the periodic timer
package ptm_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned CNT_W  = 10;
  localparam int unsigned ADDR_W = 6;

  // ==========================================================================
  // register byte addresses (one aligned word each)
  localparam logic [5:0] ADDR_CNT_LO   = 6'h00;
  localparam logic [5:0] ADDR_CNT_HI   = 6'h04;
  localparam logic [5:0] ADDR_CMPA_LO  = 6'h08;
  localparam logic [5:0] ADDR_CMPA_HI  = 6'h0C;
  localparam logic [5:0] ADDR_PER_LO   = 6'h10;
  localparam logic [5:0] ADDR_PER_HI   = 6'h14;
  localparam logic [5:0] ADDR_CTRL0    = 6'h18;
  localparam logic [5:0] ADDR_CTRL1    = 6'h1C;
  localparam logic [5:0] ADDR_STATUS   = 6'h20;

  // ==========================================================================
  // field positions
  localparam int unsigned C0_RUN_BIT   = 3;
  localparam int unsigned C0_PAUSE_BIT = 7;
  localparam int unsigned ST_AF_BIT    = 0;
  localparam int unsigned ST_PF_BIT    = 1;

  // ==========================================================================
  // reset values
  localparam logic [7:0]       CTRL_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 10'h001;

  // ==========================================================================
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // operating modes and output actions
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'h0,
    MODE_CAPTURE = 2'h1,
    MODE_PWM     = 2'h2,
    MODE_TIMER   = 2'h3
  } op_mode_t;

  typedef enum logic [1:0] {
    ACT_NONE_INACT = 2'h0,
    ACT_LOW_ACT    = 2'h1,
    ACT_HIGH_WAVE  = 2'h2,
    ACT_TOGGLE_SP  = 2'h3
  } out_action_t;

  // control register one, msb first
  typedef struct packed {
    op_mode_t    mode;
    out_action_t action;
    logic        output_initial_level;
    logic        output_invert;
    logic        capture_source;
    logic        counter_clear_select;
  } timer_control_one_t;

  // settings passed to the counter core
  typedef struct packed {
    logic                 run_control;
    logic                 counter_pause;
    timer_control_one_t   c1;
    logic [CNT_W-1:0]     compare_a_value;
    logic [CNT_W-1:0]     period_compare_value;
  } timer_cfg_t;

  // events from the counter core
  typedef struct packed {
    logic a_match;
    logic p_match;
    logic run_rise;
  } timer_evt_t;

endpackage

// ==== rtl/ptm_counter.sv ====
// module: 10-bit counter with compare a and period compare
`timescale 1ns/1ps
module ptm_counter #(
  parameter int unsigned W = ptm_pkg::CNT_W
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire ptm_pkg::timer_cfg_t cfg,
  output logic [W-1:0]             count_q,
  output ptm_pkg::timer_evt_t      evt
);

  if (W != ptm_pkg::CNT_W) begin : g_bad_width
    $error("counter width must match package");
  end

  logic         run_q;
  logic [W-1:0] cnt_inc;
  logic         a_eq;
  logic         p_eq;
  logic         clr_on_a;
  logic         active;

  always_ff @(posedge aclk) begin
    if (!aresetn) run_q <= 1'b0;
    else          run_q <= cfg.run_control;
  end

  assign active   = run_q && cfg.run_control && !cfg.counter_pause;
  assign cnt_inc  = count_q + ptm_pkg::CNT_ONE;
  // a compare fires on the edge at which the count would reach its value,
  // so the count runs 0 to value-1 and a value of n gives an n-count period
  assign a_eq     = active && (cnt_inc == cfg.compare_a_value);
  assign p_eq     = active && (cnt_inc == cfg.period_compare_value);
  // pwm ignores the clear select and always uses the period compare
  assign clr_on_a = cfg.c1.counter_clear_select &&
                    (cfg.c1.mode != ptm_pkg::MODE_PWM);

  assign evt.run_rise = cfg.run_control && !run_q;
  assign evt.a_match  = a_eq;
  assign evt.p_match  = p_eq && !clr_on_a;

  // a zero period compare matches on the wrap, giving 1024 counts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= ptm_pkg::CNT_ZERO;
    end else if (evt.run_rise) begin
      count_q <= ptm_pkg::CNT_ZERO;
    end else if (active) begin
      if ((clr_on_a && a_eq) || (!clr_on_a && p_eq)) begin
        count_q <= ptm_pkg::CNT_ZERO;
      end else begin
        count_q <= cnt_inc;
      end
    end
  end

endmodule // ptm_counter

// ==== rtl/ptm_output.sv ====
// module: timer output pin logic for compare and pwm modes
`timescale 1ns/1ps
module ptm_output #(
  parameter int unsigned W = ptm_pkg::CNT_W
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire ptm_pkg::timer_cfg_t cfg,
  input  wire logic [W-1:0]        count,
  input  wire ptm_pkg::timer_evt_t evt,
  output logic                     timer_output_pin,
  output logic                     timer_output_enable
);

  if (W != ptm_pkg::CNT_W) begin : g_bad_width
    $error("output width must match package");
  end

  logic cmp_q;
  logic pwm_act;
  logic lvl;
  logic pin_d;

  // compare-mode latch: touched only by an a match or a run rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_q <= 1'b0;
    end else if (evt.run_rise) begin
      cmp_q <= cfg.c1.output_initial_level;
    end else if (evt.a_match && cfg.c1.mode == ptm_pkg::MODE_COMPARE) begin
      unique case (cfg.c1.action)
        ptm_pkg::ACT_NONE_INACT: cmp_q <= cmp_q;
        ptm_pkg::ACT_LOW_ACT:    cmp_q <= 1'b0;
        ptm_pkg::ACT_HIGH_WAVE:  cmp_q <= 1'b1;
        ptm_pkg::ACT_TOGGLE_SP:  cmp_q <= ~cmp_q;
      endcase
    end
  end

  // active while count below duty; duty >= period gives 100 percent
  always_comb begin
    pwm_act = (count < cfg.compare_a_value) ||
              ((cfg.period_compare_value != ptm_pkg::CNT_ZERO) &&
               (cfg.compare_a_value >= cfg.period_compare_value));
    unique case (cfg.c1.action)
      ptm_pkg::ACT_NONE_INACT: lvl = 1'b0;
      ptm_pkg::ACT_LOW_ACT:    lvl = 1'b1;
      ptm_pkg::ACT_HIGH_WAVE:  lvl = pwm_act;
      ptm_pkg::ACT_TOGGLE_SP:  lvl = pwm_act && cfg.run_control;
    endcase
    // active level chosen by the initial-level bit, then inverted
    pin_d = (lvl ~^ cfg.c1.output_initial_level) ^
            cfg.c1.output_invert;
    if (cfg.c1.mode != ptm_pkg::MODE_PWM) begin
      pin_d = cmp_q ^ cfg.c1.output_invert;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_output_pin    <= 1'b0;
      timer_output_enable <= 1'b0;
    end else begin
      timer_output_pin    <= pin_d;
      timer_output_enable <= (cfg.c1.mode == ptm_pkg::MODE_COMPARE) ||
                             (cfg.c1.mode == ptm_pkg::MODE_PWM);
    end
  end

endmodule // ptm_output

// ==== sim/ptm_checker.sv ====
// checker: bus and pin assertions for the periodic timer
`timescale 1ns/1ps
module ptm_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [5:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [5:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        timer_output_pin,
  input wire logic        timer_output_enable
);
  // ==========================================================================
  // shadows of the read address and of control register one
  logic [5:0]                  ra_q;
  logic [7:0]                  c1_q;
  ptm_pkg::timer_control_one_t c1;
  logic                        wr_go, hi_rd, lo_rd, tmr, cmp, fz, lvl;
  assign c1    = c1_q;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                 && s_axi_wready;
  assign hi_rd = ra_q inside {ptm_pkg::ADDR_CNT_HI, ptm_pkg::ADDR_CMPA_HI,
                              ptm_pkg::ADDR_PER_HI};
  assign lo_rd = ra_q inside {ptm_pkg::ADDR_CNT_LO, ptm_pkg::ADDR_CMPA_LO,
                              ptm_pkg::ADDR_PER_LO};
  assign tmr   = c1.mode == ptm_pkg::MODE_TIMER;
  assign cmp   = c1.mode == ptm_pkg::MODE_COMPARE;
  assign fz    = c1.mode == ptm_pkg::MODE_PWM && !c1_q[5];
  // forced level: active when action bit 0 set, then inverted
  assign lvl   = (c1_q[4] ? c1.output_initial_level
                  : !c1.output_initial_level) ^ c1.output_invert;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ra_q <= 6'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      ra_q <= s_axi_araddr;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c1_q <= 8'h00;
    end else if (wr_go && s_axi_wstrb[0]
                 && s_axi_awaddr == ptm_pkg::ADDR_CTRL1) begin
      c1_q <= s_axi_wdata[7:0];
    end
  end
  // ==========================================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    wr_go;
  endsequence
  sequence s_wr_resp;
    ##[1:2] s_axi_bvalid;
  endsequence
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  wr_answer_a: assert property (s_wr_take |-> s_wr_resp)
    else $error("write answer late");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write resp dropped");
  hi_zero_a: assert property (s_axi_rvalid && hi_rd |->
    s_axi_rdata[31:2] == 30'h0) else $error("high byte upper bits set");
  lo_byte_a: assert property (s_axi_rvalid && lo_rd |->
    s_axi_rdata[31:8] == 24'h0) else $error("low byte wider than 8");
  timer_pin_a: assert property (tmr [*4] |-> !timer_output_enable)
    else $error("pin driven in timer mode");
  compare_pin_a: assert property (cmp [*4] |-> timer_output_enable)
    else $error("pin not driven in compare mode");
  // the shadow leads the pin by two cycles, so a new setting must settle
  pwm_force_a: assert property ((fz && $stable(c1_q)) [*4] |->
    timer_output_pin == lvl) else $error("forced pwm level wrong");
endmodule // ptm_checker

bind ptm_top ptm_checker chk_i (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .timer_output_pin, .timer_output_enable);

// ==== sim/pin_monitor.sv ====
// model: load on the timer output pin, counts cycles spent high
`timescale 1ns/1ps
module pin_monitor (
  input  wire logic        aclk,
  input  wire logic        clr,
  input  wire logic        pin,
  input  wire logic        en,
  output logic      [15:0] hi_cnt
);
  // an undriven pin reads low through the pull-down of the load
  always_ff @(posedge aclk) begin
    if (clr) begin
      hi_cnt <= 16'h0000;
    end else begin
      hi_cnt <= hi_cnt + {15'h0000, pin & en};
    end
  end
endmodule // pin_monitor

// ==== sim/testbench.sv ====
// testbench: register and pin scenarios for the periodic timer
`timescale 1ns/1ps
module testbench;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, pin, en, clr;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v1, v2;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, last_r;
  logic [15:0] hi_cnt;
  int          err_count, n_tests;

  ptm_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer_output_pin(pin), .timer_output_enable(en));
  pin_monitor load_i (.aclk(aclk), .clr(clr), .pin(pin), .en(en),
    .hi_cnt(hi_cnt));

  // ==========================================================================
  // tasks
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(logic [5:0] a, logic [7:0] d);
    logic ta, tw, tb, tv;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      tv = bvalid;
      tb = bvalid && bready;
      last_r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      // answer waits one cycle so the response hold checks see a stall
      if (tv && !tb) bready <= 1'b1;
    end while (!tb);
    bready <= 1'b0;
  endtask
  task automatic rd(logic [5:0] a, output logic [31:0] d);
    logic ta, tr, tv;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arready;
      tv = rvalid;
      tr = rvalid && rready;
      d = rdata;
      last_r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tv && !tr) rready <= 1'b1;
    end while (!tr);
    rready <= 1'b0;
  endtask
  task automatic rdc(string n, logic [5:0] a, logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(n, e, d);
  endtask
  function automatic logic [7:0] c1f(logic [1:0] m, logic [1:0] a,
                                     logic i, logic v, logic c);
    return {m, a, i, v, 1'b0, c};
  endfunction
  task automatic cfg(logic [9:0] a, logic [9:0] p, logic [7:0] c);
    wr(ptm_pkg::ADDR_CTRL0, 8'h00);
    wr(ptm_pkg::ADDR_CMPA_LO, a[7:0]);
    wr(ptm_pkg::ADDR_CMPA_HI, {6'h00, a[9:8]});
    wr(ptm_pkg::ADDR_PER_LO, p[7:0]);
    wr(ptm_pkg::ADDR_PER_HI, {6'h00, p[9:8]});
    wr(ptm_pkg::ADDR_CTRL1, c);
    wr(ptm_pkg::ADDR_CTRL0, 8'h08);
  endtask
  // high cycles over a window of whole periods, settled first
  task automatic rc(string n, logic [9:0] a, logic [9:0] p, logic [7:0] c,
                    int w, int e);
    cfg(a, p, c);
    repeat (w) @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    repeat (w) @(posedge aclk);
    #1;
    chk(n, 32'(e), {16'h0000, hi_cnt});
  endtask
  task automatic flg(logic [31:0] e);
    wr(ptm_pkg::ADDR_STATUS, 8'h03);
    repeat (100) @(posedge aclk);
    rdc("flags", ptm_pkg::ADDR_STATUS, e);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================================
  // clock, watchdog and scenarios
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    end_sim();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, clr} = 7'h00;
    {awaddr, araddr, wdata} = 44'h0;
    wstrb = 4'hF;
    err_count = 0;
    n_tests = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) rdc("reset", 6'(4 * i), 32'h0);
    wr(ptm_pkg::ADDR_CMPA_LO, 8'hFF);
    wr(ptm_pkg::ADDR_CMPA_HI, 8'hFF);
    wr(ptm_pkg::ADDR_PER_HI, 8'hFF);
    rdc("a_lo", ptm_pkg::ADDR_CMPA_LO, 32'hFF);
    rdc("a_hi", ptm_pkg::ADDR_CMPA_HI, 32'h3);
    rdc("p_hi", ptm_pkg::ADDR_PER_HI, 32'h3);
    wr(ptm_pkg::ADDR_CNT_LO, 8'h55);
    rdc("cnt_ro", ptm_pkg::ADDR_CNT_LO, 32'h0);
    wr(6'h24, 8'h01);
    chk("unmapped", 32'(ptm_pkg::RESP_SLVERR), 32'(last_r));
    rdc("unmapped_rd", 6'h24, 32'h0);
    chk("unmapped_rr", 32'(ptm_pkg::RESP_SLVERR), 32'(last_r));
    for (int m = 0; m < 4; m++) begin
      wr(ptm_pkg::ADDR_CTRL1, 8'(m << 6));
      repeat (4) @(posedge aclk);
      #1;
      chk("enable", 32'(m == 0 || m == 2), 32'(en));
    end
    wr(ptm_pkg::ADDR_CTRL0, 8'h88);
    rdc("cnt_start", ptm_pkg::ADDR_CNT_LO, 32'h0);
    wr(ptm_pkg::ADDR_CTRL0, 8'h08);
    rd(ptm_pkg::ADDR_CNT_LO, v1);
    repeat (20) @(posedge aclk);
    rd(ptm_pkg::ADDR_CNT_LO, v2);
    chk("cnt_step", v1 + 32'h18, v2);
    wr(ptm_pkg::ADDR_CTRL0, 8'h88);
    rd(ptm_pkg::ADDR_CNT_LO, v1);
    rdc("cnt_pause", ptm_pkg::ADDR_CNT_LO, v1);
    wr(ptm_pkg::ADDR_CTRL0, 8'h00);
    rd(ptm_pkg::ADDR_CNT_LO, v1);
    rdc("cnt_hold", ptm_pkg::ADDR_CNT_LO, v1);
    rc("tmr", 10'h5, 10'h14, c1f(2'h3, 2'h0, 1'b0, 1'b0, 1'b0),
       80, 0);
    flg(32'h3);
    rc("cclr", 10'hA, 10'h3, c1f(2'h0, 2'h3, 1'b0, 1'b0, 1'b1),
       40, 20);
    flg(32'h1);
    rc("ctog", 10'h5, 10'h14, c1f(2'h0, 2'h3, 1'b0, 1'b0, 1'b0),
       80, 40);
    flg(32'h3);
    rc("cnone", 10'h5, 10'h14, c1f(2'h0, 2'h0, 1'b1, 1'b0, 1'b0),
       80, 80);
    rc("clow", 10'h5, 10'h14, c1f(2'h0, 2'h1, 1'b1, 1'b0, 1'b0),
       80, 0);
    rc("chigh", 10'h5, 10'h14, c1f(2'h0, 2'h2, 1'b0, 1'b0, 1'b0),
       80, 80);
    cfg(10'h1F4, 10'h0, c1f(2'h0, 2'h2, 1'b0, 1'b0, 1'b0));
    repeat (5) @(posedge aclk);
    #1;
    chk("init", 32'h0, 32'(pin));
    repeat (600) @(posedge aclk);
    #1;
    chk("match", 32'h1, 32'(pin));
    wr(ptm_pkg::ADDR_CTRL0, 8'h00);
    wr(ptm_pkg::ADDR_CTRL0, 8'h08);
    repeat (5) @(posedge aclk);
    #1;
    chk("reload", 32'h0, 32'(pin));
    rc("pwm", 10'h5, 10'h14, c1f(2'h2, 2'h2, 1'b1, 1'b0, 1'b1),
       80, 20);
    rc("pwm_lo", 10'h5, 10'h14, c1f(2'h2, 2'h2, 1'b0, 1'b0, 1'b0),
       80, 60);
    rc("pwm_inv", 10'h5, 10'h14, c1f(2'h2, 2'h2, 1'b1, 1'b1, 1'b0),
       80, 60);
    rc("pwm_full", 10'h19, 10'h14, c1f(2'h2, 2'h2, 1'b1, 1'b0, 1'b0),
       80, 80);
    rc("pwm_p0", 10'h100, 10'h0, c1f(2'h2, 2'h2, 1'b1, 1'b0, 1'b0),
       1024, 256);
    rc("pwm_sp", 10'h5, 10'h14, c1f(2'h2, 2'h3, 1'b1, 1'b0, 1'b0),
       80, 20);
    rc("pwm_off", 10'h5, 10'h14, c1f(2'h2, 2'h0, 1'b1, 1'b0, 1'b0),
       80, 0);
    rc("pwm_on", 10'h5, 10'h14, c1f(2'h2, 2'h1, 1'b1, 1'b0, 1'b0),
       80, 80);
    flg(32'h3);
    end_sim();
  end
endmodule // testbench
